/* File: design/led_mode_irq.v */
// mode control and interrupt status block of a nine-sink led driver
//
// Behaviour
// - config 1: clear with pending, release 50us
// - config 0: clear with pending, stay asserted
// - standby bit 0 turns all sinks off and holds 1x gain; registers and interrupts keep running
// - max current write forces 1x gain
// - inhibit: gain up freely, down when off
// - no inhibit: gain follows load both ways
// - independent master enables independent group sinks
// - any direct enable outside the backlight group overrides independent master
// - backlight master enables backlight group sinks
// - flag when selected independent sinks all off
// - flag when backlight fade reaches off
// - flag on short or overload detection
// - flag on thermal shutdown
// - flag on charge pump overvoltage
// - writing one clears flag, else unchanged
// - enable gates interrupt, flag still sets
`include "led_mode_irq_map.vh"
`timescale 1ns/1ps
`default_nettype none

module led_mode_irq (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register access port from the serial interface
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_ff,
  // sink group configuration and state from the fade engines
  input wire [8:0] bl_group_sel,
  input wire [8:0] per_sink_direct_enable,
  input wire [8:0] indep_off_sel,
  input wire [8:0] sink_on,
  input wire bl_fade_off_done,
  // asynchronous analog detectors
  input wire short_det,
  input wire tsd_det,
  input wire ovp_det,
  input wire load_needs_more,
  input wire load_needs_less,
  // outputs to the analog core and the host
  output reg [8:0] indep_sink_en_ff,
  output reg [8:0] backlight_sink_en_ff,
  output reg normal_run_ff,
  output reg [1:0] cp_gain_ff,
  output reg host_irq_n_ff
);

  // ****************************************************************
  // registers and wires
  // ****************************************************************
  reg [7:0] mode_control_ff;
  reg [7:0] interrupt_flags_ff;
  reg [7:0] interrupt_enable_ff;
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  reg [2:0] det_dly_ff;
  reg indep_any_on_ff;
  reg [10:0] gap_cnt_ff;
  reg [7:0] nxt_mode;
  reg [7:0] nxt_flags;
  reg [7:0] nxt_enable;
  reg [7:0] nxt_rdata;
  reg [7:0] flag_set;
  reg [7:0] flag_clr;
  reg [1:0] nxt_gain;
  reg [10:0] nxt_gap;
  wire int_cfg;
  wire normal_not_standby;
  wire gain_reset_on_max_write;
  wire gain_down_inhibit;
  wire indep_sink_master_en;
  wire backlight_master_en;
  wire [2:0] det_now;
  wire [2:0] det_rise;
  wire indep_sel_on;
  wire all_sinks_off;
  wire max_wr;
  wire clr_hit;
  wire pending_now;
  wire pending_next;

  assign int_cfg = mode_control_ff[`MD_INT_CFG_BIT];
  assign normal_not_standby = mode_control_ff[`MD_NORMAL_BIT];
  assign gain_reset_on_max_write = mode_control_ff[`MD_GAIN_RST_BIT];
  assign gain_down_inhibit = mode_control_ff[`MD_GDWN_INH_BIT];
  assign indep_sink_master_en = mode_control_ff[`MD_INDEP_EN_BIT];
  assign backlight_master_en = mode_control_ff[`MD_BACKLIGHT_MASTER_EN_BIT];

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // analog comparators are asynchronous, so two stages before any use
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      det_dly_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= {load_needs_less, load_needs_more, ovp_det, tsd_det,
                   short_det};
      sync2_ff <= sync1_ff;
      det_dly_ff <= sync2_ff[2:0];
    end
  end

  // edge detection on the second stage only
  assign det_now = sync2_ff[2:0];
  assign det_rise = det_now & ~det_dly_ff;

  // ****************************************************************
  // event detection
  // ****************************************************************
  // selected independent sinks: flag fires on the on-to-off transition
  assign indep_sel_on = |(sink_on & indep_off_sel & ~bl_group_sel);
  assign all_sinks_off = ~|sink_on;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      indep_any_on_ff <= 1'b0;
    else
      indep_any_on_ff <= indep_sel_on;
  end

  // hardware set terms, one per flag
  always @*
  begin
    flag_set = 8'h00;
    flag_set[`FL_INDEP_OFF_BIT] = indep_any_on_ff & ~indep_sel_on;
    flag_set[`FL_BL_OFF_BIT] = bl_fade_off_done;
    flag_set[`FL_SHORT_BIT] = det_rise[0];
    flag_set[`FL_TSD_BIT] = det_rise[1];
    flag_set[`FL_OVP_BIT] = det_rise[2];
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  assign max_wr = reg_wr & (reg_addr == `BL_MAX_CURRENT_ADDR);

  // write-one-to-clear; a set in the same cycle wins over the clear
  always @*
  begin
    flag_clr = 8'h00;
    if (reg_wr && reg_addr == `INTERRUPT_FLAGS_ADDR)
      flag_clr = reg_wdata & `FL_MASK;
    nxt_flags = ((interrupt_flags_ff & ~flag_clr) | flag_set) & `FL_MASK;
  end

  // plain read/write registers; reserved bits stay zero
  always @*
  begin
    nxt_mode = mode_control_ff;
    nxt_enable = interrupt_enable_ff;
    if (reg_wr && reg_addr == `MODE_CONTROL_ADDR)
      nxt_mode = reg_wdata & `MD_WR_MASK;
    if (reg_wr && reg_addr == `INTERRUPT_ENABLE_ADDR)
      nxt_enable = reg_wdata & `FL_MASK;
  end

  // read data: reads have no side effect on the flags
  always @*
  begin
    nxt_rdata = reg_rdata_ff;
    if (reg_rd)
    begin
      case (reg_addr)
        `MODE_CONTROL_ADDR: nxt_rdata = mode_control_ff;
        `INTERRUPT_FLAGS_ADDR: nxt_rdata = interrupt_flags_ff;
        `INTERRUPT_ENABLE_ADDR: nxt_rdata = interrupt_enable_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_control_ff <= `MODE_CONTROL_RST;
      interrupt_flags_ff <= `INTERRUPT_FLAGS_RST;
      interrupt_enable_ff <= `INTERRUPT_ENABLE_RST;
      reg_rdata_ff <= 8'h00;
    end
    else
    begin
      mode_control_ff <= nxt_mode;
      interrupt_flags_ff <= nxt_flags;
      interrupt_enable_ff <= nxt_enable;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // sink enables and standby
  // ****************************************************************
  // standby keeps the registers alive but turns every sink off
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      normal_run_ff <= 1'b0;
      indep_sink_en_ff <= 9'h000;
      backlight_sink_en_ff <= 9'h000;
    end
    else
    begin
      normal_run_ff <= normal_not_standby;
      if (!normal_not_standby)
      begin
        indep_sink_en_ff <= 9'h000;
        backlight_sink_en_ff <= 9'h000;
      end
      else
      begin
        // direct enables take over the whole independent group
        if (|(per_sink_direct_enable & ~bl_group_sel))
          indep_sink_en_ff <= per_sink_direct_enable & ~bl_group_sel;
        else
          indep_sink_en_ff <= {9{indep_sink_master_en}} & ~bl_group_sel;
        backlight_sink_en_ff <= {9{backlight_master_en}} & bl_group_sel;
      end
    end
  end

  // ****************************************************************
  // charge pump gain policy
  // ****************************************************************
  always @*
  begin
    nxt_gain = cp_gain_ff;
    if (max_wr && gain_reset_on_max_write)
      nxt_gain = `GAIN_1X;
    else if (!normal_not_standby)
      nxt_gain = `GAIN_1X;
    else if (sync2_ff[3] && cp_gain_ff != `GAIN_2X)
      nxt_gain = cp_gain_ff + 2'h1;
    else if (sync2_ff[4] && cp_gain_ff != `GAIN_1X &&
             (!gain_down_inhibit || all_sinks_off))
      nxt_gain = cp_gain_ff - 2'h1;
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cp_gain_ff <= `GAIN_1X;
    else
      cp_gain_ff <= nxt_gain;
  end

  // ****************************************************************
  // host interrupt line
  // ****************************************************************
  assign pending_now = |(interrupt_flags_ff & interrupt_enable_ff);
  assign pending_next = |(nxt_flags & nxt_enable);
  assign clr_hit = |(flag_clr & interrupt_flags_ff);

  // with the config bit high, release gap restarts on each clearing write that leaves work pending
  always @*
  begin
    nxt_gap = gap_cnt_ff;
    if (clr_hit && pending_next && int_cfg)
      nxt_gap = `INT_GAP_CYCLES;
    else if (gap_cnt_ff != 11'h000)
      nxt_gap = gap_cnt_ff - 11'h001;
  end

  // with the config bit low the line never drops while pending
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap_cnt_ff <= 11'h000;
      host_irq_n_ff <= 1'b1;
    end
    else
    begin
      gap_cnt_ff <= nxt_gap;
      host_irq_n_ff <= ~(pending_now & (nxt_gap == 11'h000));
    end
  end

endmodule // led_mode_irq

`default_nettype wire

/* File: common/led_mode_irq_map.vh */
// register offsets, field positions, reset values and timing counts
`ifndef LED_MODE_IRQ_MAP_VH
`define LED_MODE_IRQ_MAP_VH

// register offsets on the register access port
`define MODE_CONTROL_ADDR 8'h01
`define INTERRUPT_FLAGS_ADDR 8'h02
`define INTERRUPT_ENABLE_ADDR 8'h03
`define BL_MAX_CURRENT_ADDR 8'h13

// mode_control field positions
`define MD_INT_CFG_BIT 6
`define MD_NORMAL_BIT 5
`define MD_GAIN_RST_BIT 4
`define MD_GDWN_INH_BIT 3
`define MD_INDEP_EN_BIT 2
`define MD_BACKLIGHT_MASTER_EN_BIT 0
`define MD_WR_MASK 8'h7D

// interrupt_flags and interrupt_enable field positions
`define FL_INDEP_OFF_BIT 6
`define FL_BL_OFF_BIT 5
`define FL_SHORT_BIT 4
`define FL_TSD_BIT 3
`define FL_OVP_BIT 2
`define FL_MASK 8'h7C

// reset values
`define MODE_CONTROL_RST 8'h00
`define INTERRUPT_FLAGS_RST 8'h00
`define INTERRUPT_ENABLE_RST 8'h00

// charge pump gain codes
`define GAIN_1X 2'h0
`define GAIN_1P5X 2'h1
`define GAIN_2X 2'h2

// interrupt release gap: 50 us at the 25 MHz clock, in cycles
// sized to the 11-bit gap counter so no truncation is needed
`define INT_GAP_CYCLES 11'h4E2

`endif

/* File: test/led_mode_irq_checker.sv */
// port checker for the led mode and interrupt block
`timescale 1ns/1ps
`default_nettype none
module led_mode_irq_checker (
  // clock, reset and register port
  input wire clk,
  input wire sys_rst,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  // sink inputs and block outputs
  input wire [8:0] bl_group_sel,
  input wire [8:0] per_sink_direct_enable,
  input wire [8:0] sink_on,
  input wire [8:0] indep_sink_en_ff,
  input wire [8:0] backlight_sink_en_ff,
  input wire normal_run_ff,
  input wire [1:0] cp_gain_ff,
  input wire host_irq_n_ff
);
  // ****************
  // shadow registers
  // ****************
  logic [7:0] mode_ff;
  logic [7:0] ien_ff;
  wire [8:0] dir = per_sink_direct_enable & ~bl_group_sel;
  wire [8:0] ind = !mode_ff[5] ? 9'h000 : (|dir) ? dir :
    {9{mode_ff[2]}} & ~bl_group_sel;
  wire gwr = reg_wr && reg_addr == 8'h13;
  // writes that may release the line: flag clear or enable change
  wire clr_wr = reg_wr && (reg_addr == 8'h02 || reg_addr == 8'h03);
  // mirror of what the host wrote, reserved bits dropped
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      mode_ff <= 8'h00;
      ien_ff <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h01) mode_ff <= reg_wdata & 8'h7D;
      if (reg_addr == 8'h03) ien_ff <= reg_wdata & 8'h7C;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_NORMAL: assert property (normal_run_ff == $past(mode_ff[5]))
    else $error("run mode off");
  AST_BL: assert property (backlight_sink_en_ff ==
    $past({9{mode_ff[5] & mode_ff[0]}} & bl_group_sel)) else $error("backlight_master_en");
  AST_IND: assert property (indep_sink_en_ff == $past(ind))
    else $error("indep en");
  AST_GRST: assert property (gwr && mode_ff[4] |=> cp_gain_ff == 2'h0)
    else $error("gain not 1x");
  AST_GSTEP: assert property (cp_gain_ff > $past(cp_gain_ff) |->
    cp_gain_ff == $past(cp_gain_ff) + 2'h1) else $error("gain jump");
  AST_GINH: assert property ($past(mode_ff[3] && mode_ff[5] &&
    |sink_on && !gwr) |-> cp_gain_ff >= $past(cp_gain_ff))
    else $error("gain down");
  AST_IMASK: assert property ($past(ien_ff) == 8'h00 |-> host_irq_n_ff)
    else $error("masked irq");
  // gap release follows the write by one edge, a plain release by two
  AST_IRISE: assert property ($rose(host_irq_n_ff) |->
    $past(clr_wr) || $past(clr_wr, 2))
    else $error("irq release");
endmodule // led_mode_irq_checker
bind led_mode_irq led_mode_irq_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .bl_group_sel(bl_group_sel), .sink_on(sink_on),
  .per_sink_direct_enable(per_sink_direct_enable),
  .indep_sink_en_ff(indep_sink_en_ff), .normal_run_ff(normal_run_ff),
  .backlight_sink_en_ff(backlight_sink_en_ff), .cp_gain_ff(cp_gain_ff),
  .host_irq_n_ff(host_irq_n_ff));
`default_nettype wire

/* File: test/host_reg_model.sv */
// host model driving the byte register port
`timescale 1ns/1ps
`default_nettype none
module host_reg_model (
  // clock
  input wire clk,
  // register port
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'hA5,
  output logic [7:0] reg_wdata = 8'h5A,
  input wire [7:0] reg_rdata_ff
);
  // one strobe cycle; data inverted after so stale bytes never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata_ff;
  endtask
endmodule // host_reg_model
`default_nettype wire

/* File: test/tb_led_mode_irq.sv */
// self-checking bench for the led mode and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_led_mode_irq;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd, normal_run_ff, host_irq_n_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, rv;
  logic [8:0] bl_group_sel = 9'h0F0, per_sink_direct_enable = 9'h000;
  logic [8:0] indep_off_sel = 9'h003, sink_on = 9'h000;
  logic [8:0] indep_sink_en_ff, backlight_sink_en_ff;
  logic bl_fade_off_done = 1'b0, short_det = 1'b0, tsd_det = 1'b0;
  logic ovp_det = 1'b0, load_needs_more = 1'b0, load_needs_less = 1'b0;
  logic [1:0] cp_gain_ff;
  int fails = 0, total_checks = 0, cycles = 0, n;
  always #20 clk = ~clk;
  led_mode_irq u_led_mode_irq (.clk(clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .bl_group_sel(bl_group_sel), .indep_off_sel(indep_off_sel),
    .per_sink_direct_enable(per_sink_direct_enable), .sink_on(sink_on),
    .bl_fade_off_done(bl_fade_off_done), .short_det(short_det),
    .tsd_det(tsd_det), .ovp_det(ovp_det), .cp_gain_ff(cp_gain_ff),
    .load_needs_more(load_needs_more), .load_needs_less(load_needs_less),
    .indep_sink_en_ff(indep_sink_en_ff), .normal_run_ff(normal_run_ff),
    .backlight_sink_en_ff(backlight_sink_en_ff),
    .host_irq_n_ff(host_irq_n_ff));
  host_reg_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff));
  // ******************
  // compare and access
  // ******************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(a, d);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rv);
    chk(rv, e);
  endtask
  // ramp the load request for a while, then let the synchroniser drain
  task automatic ld(input logic up, input logic dn);
    {load_needs_more, load_needs_less} = {up, dn};
    cyc(8);
    {load_needs_more, load_needs_less} = 2'b00;
    cyc(4);
  endtask
  task automatic summarize;
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well above the longest release gap
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      summarize;
    end
  end
  // ********
  // sequence
  // ********
  initial
  begin
    cyc(12);
    sys_rst = 1'b0;
    for (n = 1; n < 6; n++) r(8'(n), 8'h00);
    w(8'h01, 8'hFF);
    r(8'h01, 8'h7D);
    chk(backlight_sink_en_ff, 9'h0F0);
    chk(indep_sink_en_ff, 9'h10F);
    chk(normal_run_ff, 1'b1);
    per_sink_direct_enable = 9'h012;
    cyc(2);
    chk(indep_sink_en_ff, 9'h002);
    per_sink_direct_enable = 9'h000;
    w(8'h01, 8'h5D);
    cyc(2);
    chk(backlight_sink_en_ff | indep_sink_en_ff, 9'h000);
    chk(normal_run_ff, 1'b0);
    w(8'h01, 8'h20);
    for (n = 0; n < 3; n++)
    begin
      {short_det, tsd_det, ovp_det} = 3'b100 >> n;
      cyc(2);
    end
    {short_det, tsd_det, ovp_det, bl_fade_off_done} = 4'b0001;
    sink_on = 9'h003;
    cyc(1);
    bl_fade_off_done = 1'b0;
    sink_on = 9'h000;
    cyc(5);
    chk(host_irq_n_ff, 1'b1);
    r(8'h02, 8'h7C);
    w(8'h02, 8'h00);
    r(8'h02, 8'h7C);
    w(8'h02, 8'h04);
    r(8'h02, 8'h78);
    w(8'h03, 8'hFF);
    cyc(2);
    chk(host_irq_n_ff, 1'b0);
    w(8'h02, 8'h08);
    for (n = 0; n < 4; n++)
    begin
      chk(host_irq_n_ff, 1'b0);
      cyc(1);
    end
    w(8'h01, 8'h60);
    w(8'h02, 8'h10);
    // count every high cycle from the clearing edge onwards
    n = 0;
    while (host_irq_n_ff === 1'b1 && n < 2000)
    begin
      n++;
      cyc(1);
    end
    chk(n[15:0], 16'h04E2);
    chk(host_irq_n_ff, 1'b0);
    w(8'h01, 8'h28);
    sink_on = 9'h001;
    ld(1'b1, 1'b0);
    ld(1'b0, 1'b1);
    chk(cp_gain_ff, 2'h2);
    sink_on = 9'h000;
    ld(1'b0, 1'b1);
    chk(cp_gain_ff, 2'h0);
    w(8'h01, 8'h20);
    sink_on = 9'h001;
    ld(1'b1, 1'b0);
    chk(cp_gain_ff, 2'h2);
    ld(1'b0, 1'b1);
    chk(cp_gain_ff, 2'h0);
    ld(1'b1, 1'b0);
    w(8'h13, 8'h10);
    cyc(2);
    chk(cp_gain_ff, 2'h2);
    w(8'h01, 8'h30);
    w(8'h13, 8'h10);
    chk(cp_gain_ff, 2'h0);
    summarize;
  end
endmodule // tb_led_mode_irq
`default_nettype wire
